// >>> hdl/dits_defines.vh
// Register offsets, indices, reset values, commands and timing for the discrete I/O sequencer
`ifndef DITS_DEFINES_VH
`define DITS_DEFINES_VH
`define DITS_OFF_UNIT 16'h9c85
`define DITS_OFF_OPCMD 16'ha30f
`define DITS_OFF_WINDOW 16'ha35f
`define DITS_OFF_RAMP 16'ha360
`define DITS_OFF_O1F_HI 16'ha39b
`define DITS_OFF_O1F_LO 16'ha39c
`define DITS_OFF_O1W_HI 16'ha39d
`define DITS_OFF_O1W_LO 16'ha39e
`define DITS_OFF_O2F_HI 16'ha39f
`define DITS_OFF_O2F_LO 16'ha3a0
`define DITS_OFF_O2W_HI 16'ha3a1
`define DITS_OFF_O2W_LO 16'ha3a2
`define DITS_OFF_POL 16'ha3a3
`define DITS_OFF_O1S_HI 16'ha3a4
`define DITS_OFF_O1S_LO 16'ha3a5
`define DITS_OFF_O2S_HI 16'ha3a6
`define DITS_OFF_O2S_LO 16'ha3a7
`define DITS_OFF_O1M 16'ha3a8
`define DITS_OFF_O2M 16'ha3a9
`define DITS_OFF_O1D_HI 16'ha3ad
`define DITS_OFF_O1D_LO 16'ha3ae
`define DITS_OFF_O2D_HI 16'ha3af
`define DITS_OFF_O2D_LO 16'ha3b0
`define DITS_NUM_REGS 23
`define DITS_IDX_UNIT 5'h00
`define DITS_IDX_OPCMD 5'h01
`define DITS_IDX_WINDOW 5'h02
`define DITS_IDX_RAMP 5'h03
`define DITS_IDX_POL 5'h0c
`define DITS_IDX_NONE 5'h1f
`define DITS_RST_UNIT 16'h0001
`define DITS_RST_ZERO 16'h0000
`define DITS_BCAST_ADDR 8'h00
`define DITS_CMD_STOP 16'h0000
`define DITS_CMD_START 16'h0001
`define DITS_CMD_EXIT_STBY 16'h0003
`define DITS_LFSR_SEED 16'hace1
`define DITS_CLK_HZ 25000000
`define DITS_BIAS_HOLD_MS 2500
`endif

// >>> hdl/dits_sequencer.v
// Discrete I/O, status outputs and grid-tie turn-on sequencer
`timescale 1ns/10ps
`include "dits_defines.vh"

// How it works
// - Contactors close only with emergency stop asserted
// - Emergency-stop fault while input not asserted
// - Bias supply on while bias request asserted
// - Bias holds 2.5 s after request drops
// - Island input selects grid-forming; open means grid-tie
// - Two independent configurable status outputs
// - Output polarity selected by polarity register
// - Five mask sets per status output
// - Mask one enables source, zero excludes it
// - Output is OR of all enabled sources
// - All-ones fault/warning masks pass any event
// - Contactors stay open until start command
// - Start runs pre-charge on valid grid, closes contactors
// - Exit standby: random wait, then initial ramp
// - Zero turn-on window skips random wait
// - After initial ramp use configured ramp rates
// - Accept own unit address or broadcast zero
module dits_sequencer #(
    parameter [31:0] TICK_CYCLES = `DITS_CLK_HZ,
    parameter [31:0] BIAS_HOLD_CYCLES = `DITS_BIAS_HOLD_MS * (`DITS_CLK_HZ / 1000)
) (
    input wire mclk_i,
    input wire rst_i,
    input wire emergency_stop_input_i,
    input wire bias_request_i,
    input wire island_select_i,
    input wire grid_valid_i,
    input wire precharge_done_i,
    input wire [31:0] fault_status_i,
    input wire [31:0] warning_status_i,
    input wire [31:0] der_alarm_status_i,
    input wire [15:0] misc_status_i,
    input wire req_valid_i,
    input wire [7:0] req_unit_i,
    input wire [15:0] req_addr_i,
    input wire req_write_i,
    input wire [15:0] req_wdata_i,
    output reg rsp_valid_o,
    output reg [15:0] rsp_data_o,
    output reg rsp_error_o,
    output wire contactor_close_o,
    output reg emergency_stop_input_fault_o,
    output reg bias_enable_o,
    output reg grid_forming_o,
    output reg precharge_o,
    output reg inverter_on_o,
    output reg initial_ramp_o,
    output reg rate_ramp_o,
    output reg [5:0] op_state_o,
    output reg status_output_one_o,
    output reg status_output_two_o
);

    localparam [5:0] ST_OFF = 6'h01;
    localparam [5:0] ST_CHARGE = 6'h02;
    localparam [5:0] ST_STANDBY = 6'h04;
    localparam [5:0] ST_DELAY = 6'h08;
    localparam [5:0] ST_RAMP = 6'h10;
    localparam [5:0] ST_RUN = 6'h20;

    // Maps a register offset to its storage index
    function [4:0] reg_index;
        input [15:0] addr;
        begin
            case (addr)
                `DITS_OFF_UNIT: reg_index = 5'h00;
                `DITS_OFF_OPCMD: reg_index = 5'h01;
                `DITS_OFF_WINDOW: reg_index = 5'h02;
                `DITS_OFF_RAMP: reg_index = 5'h03;
                `DITS_OFF_O1F_HI: reg_index = 5'h04;
                `DITS_OFF_O1F_LO: reg_index = 5'h05;
                `DITS_OFF_O1W_HI: reg_index = 5'h06;
                `DITS_OFF_O1W_LO: reg_index = 5'h07;
                `DITS_OFF_O2F_HI: reg_index = 5'h08;
                `DITS_OFF_O2F_LO: reg_index = 5'h09;
                `DITS_OFF_O2W_HI: reg_index = 5'h0a;
                `DITS_OFF_O2W_LO: reg_index = 5'h0b;
                `DITS_OFF_POL: reg_index = 5'h0c;
                `DITS_OFF_O1S_HI: reg_index = 5'h0d;
                `DITS_OFF_O1S_LO: reg_index = 5'h0e;
                `DITS_OFF_O2S_HI: reg_index = 5'h0f;
                `DITS_OFF_O2S_LO: reg_index = 5'h10;
                `DITS_OFF_O1M: reg_index = 5'h11;
                `DITS_OFF_O2M: reg_index = 5'h12;
                `DITS_OFF_O1D_HI: reg_index = 5'h13;
                `DITS_OFF_O1D_LO: reg_index = 5'h14;
                `DITS_OFF_O2D_HI: reg_index = 5'h15;
                `DITS_OFF_O2D_LO: reg_index = 5'h16;
                default: reg_index = `DITS_IDX_NONE;
            endcase
        end
    endfunction

    // Any masked source active
    function masked_any;
        input [31:0] src;
        input [31:0] mask;
        begin
            masked_any = |(src & mask);
        end
    endfunction

    reg [15:0] regs_reg [0:`DITS_NUM_REGS-1];
    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg [31:0] tick_cnt_reg;
    reg sec_tick_reg;
    reg [31:0] bias_cnt_reg;
    reg [15:0] lfsr_reg;
    reg [15:0] sec_cnt_reg;
    reg [15:0] sec_cnt_next;
    reg close_en_reg;
    integer k;

    wire [4:0] req_idx;
    wire unit_match;
    wire is_bcast;
    wire req_accept;
    wire wr_ok;
    wire cmd_write;
    wire cmd_start;
    wire cmd_exit;
    wire cmd_stop;
    wire rsp_needed;
    wire lfsr_fb;
    wire [31:0] rnd_prod;
    wire [31:0] o1_fault_mask;
    wire [31:0] o1_warn_mask;
    wire [31:0] o1_state_mask;
    wire [31:0] o1_der_mask;
    wire [31:0] o2_fault_mask;
    wire [31:0] o2_warn_mask;
    wire [31:0] o2_state_mask;
    wire [31:0] o2_der_mask;
    wire [31:0] state_src;
    wire [31:0] misc_src;
    wire out_one_raw;
    wire out_two_raw;

    assign req_idx = reg_index(req_addr_i);
    assign is_bcast = (req_unit_i == `DITS_BCAST_ADDR);
    assign unit_match = (req_unit_i == regs_reg[`DITS_IDX_UNIT][7:0]) | is_bcast;
    assign req_accept = req_valid_i & unit_match;
    assign wr_ok = req_accept & req_write_i & (req_idx != `DITS_IDX_NONE);
    assign cmd_write = wr_ok & (req_idx == `DITS_IDX_OPCMD);
    assign cmd_start = cmd_write & (req_wdata_i == `DITS_CMD_START);
    assign cmd_exit = cmd_write & (req_wdata_i == `DITS_CMD_EXIT_STBY);
    assign cmd_stop = cmd_write & (req_wdata_i == `DITS_CMD_STOP);
    assign rsp_needed = req_accept & ~is_bcast;

    // Random delay scaled into [0, window)
    assign rnd_prod = lfsr_reg * regs_reg[`DITS_IDX_WINDOW];

    // Feedback taps of the random source
    assign lfsr_fb = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];

    // Register storage
    always @(posedge mclk_i) begin
        if (rst_i) begin
            for (k = 0; k < `DITS_NUM_REGS; k = k + 1) begin
                regs_reg[k] <= `DITS_RST_ZERO;
            end
            regs_reg[`DITS_IDX_UNIT] <= `DITS_RST_UNIT;
        end else if (wr_ok) begin
            regs_reg[req_idx] <= req_wdata_i;
        end
    end

    // Reply strobe; broadcast requests get none, so paralleled units never talk at once
    always @(posedge mclk_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= rsp_needed;
        end
    end

    // Reply data and exception flag, held until the next reply
    always @(posedge mclk_i) begin
        if (rst_i) begin
            rsp_data_o <= 16'h0000;
            rsp_error_o <= 1'b0;
        end else begin
            if (rsp_needed) begin
                rsp_error_o <= (req_idx == `DITS_IDX_NONE);
                if (req_idx == `DITS_IDX_NONE) begin
                    rsp_data_o <= 16'h0000;
                end else if (req_write_i) begin
                    rsp_data_o <= req_wdata_i;
                end else begin
                    rsp_data_o <= regs_reg[req_idx];
                end
            end
        end
    end

    // Free-running source for the random turn-on wait
    always @(posedge mclk_i) begin
        if (rst_i) begin
            lfsr_reg <= `DITS_LFSR_SEED;
        end else begin
            lfsr_reg <= {lfsr_reg[14:0], lfsr_fb};
        end
    end

    // One-second tick enable for the delay and ramp counters
    always @(posedge mclk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 32'h00000000;
            sec_tick_reg <= 1'b0;
        end else begin
            if (tick_cnt_reg >= TICK_CYCLES - 32'h00000001) begin
                tick_cnt_reg <= 32'h00000000;
                sec_tick_reg <= 1'b1;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
                sec_tick_reg <= 1'b0;
            end
        end
    end

    // Bias supply with hold-up after request drops
    always @(posedge mclk_i) begin
        if (rst_i) begin
            bias_cnt_reg <= 32'h00000000;
            bias_enable_o <= 1'b1;
        end else if (bias_request_i) begin
            bias_cnt_reg <= 32'h00000000;
            bias_enable_o <= 1'b1;
        end else if (bias_cnt_reg < BIAS_HOLD_CYCLES) begin
            bias_cnt_reg <= bias_cnt_reg + 32'h00000001;
            bias_enable_o <= 1'b1;
        end else begin
            bias_enable_o <= 1'b0;
        end
    end

    // Turn-on sequence
    always @* begin
        state_next = state_reg;
        sec_cnt_next = sec_cnt_reg;
        case (state_reg)
            ST_OFF: begin
                if (cmd_start & emergency_stop_input_i) begin
                    state_next = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (precharge_done_i & grid_valid_i) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (cmd_exit) begin
                    if (regs_reg[`DITS_IDX_WINDOW] == 16'h0000) begin
                        state_next = ST_RAMP;
                        sec_cnt_next = regs_reg[`DITS_IDX_RAMP];
                    end else begin
                        state_next = ST_DELAY;
                        sec_cnt_next = rnd_prod[31:16];
                    end
                end
            end
            ST_DELAY: begin
                if (sec_cnt_reg == 16'h0000) begin
                    state_next = ST_RAMP;
                    sec_cnt_next = regs_reg[`DITS_IDX_RAMP];
                end else if (sec_tick_reg) begin
                    sec_cnt_next = sec_cnt_reg - 16'h0001;
                end
            end
            ST_RAMP: begin
                if (sec_cnt_reg == 16'h0000) begin
                    state_next = ST_RUN;
                end else if (sec_tick_reg) begin
                    sec_cnt_next = sec_cnt_reg - 16'h0001;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        // Stop and a dropped emergency stop win over every state
        if (cmd_stop | ~emergency_stop_input_i) begin
            state_next = ST_OFF;
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg <= ST_OFF;
            sec_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            sec_cnt_reg <= sec_cnt_next;
        end
    end

    // Sequencer outputs come from the next state so they change with op_state_o
    always @(posedge mclk_i) begin
        if (rst_i) begin
            close_en_reg <= 1'b0;
            precharge_o <= 1'b0;
            inverter_on_o <= 1'b0;
            initial_ramp_o <= 1'b0;
            rate_ramp_o <= 1'b0;
            op_state_o <= ST_OFF;
        end else begin
            close_en_reg <= (state_next != ST_OFF) & (state_next != ST_CHARGE);
            precharge_o <= (state_next == ST_CHARGE) & grid_valid_i;
            inverter_on_o <= (state_next == ST_RAMP) | (state_next == ST_RUN);
            initial_ramp_o <= (state_next == ST_RAMP);
            rate_ramp_o <= (state_next == ST_RUN);
            op_state_o <= state_next;
        end
    end

    // Registered pin levels for the host
    always @(posedge mclk_i) begin
        if (rst_i) begin
            emergency_stop_input_fault_o <= 1'b0;
            grid_forming_o <= 1'b0;
        end else begin
            emergency_stop_input_fault_o <= ~emergency_stop_input_i;
            grid_forming_o <= island_select_i;
        end
    end

    // Direct gate so a dropped emergency stop opens contactors without logic delay
    assign contactor_close_o = close_en_reg & emergency_stop_input_i;

    assign o1_fault_mask = {regs_reg[5'h04], regs_reg[5'h05]};
    assign o1_warn_mask = {regs_reg[5'h06], regs_reg[5'h07]};
    assign o1_state_mask = {regs_reg[5'h0d], regs_reg[5'h0e]};
    assign o1_der_mask = {regs_reg[5'h13], regs_reg[5'h14]};
    assign o2_fault_mask = {regs_reg[5'h08], regs_reg[5'h09]};
    assign o2_warn_mask = {regs_reg[5'h0a], regs_reg[5'h0b]};
    assign o2_state_mask = {regs_reg[5'h0f], regs_reg[5'h10]};
    assign o2_der_mask = {regs_reg[5'h15], regs_reg[5'h16]};
    assign state_src = {26'h0000000, state_reg};
    assign misc_src = {16'h0000, misc_status_i};

    // Five mask sets per output, ORed together
    assign out_one_raw = masked_any(fault_status_i, o1_fault_mask)
        | masked_any(warning_status_i, o1_warn_mask)
        | masked_any(der_alarm_status_i, o1_der_mask)
        | masked_any(state_src, o1_state_mask)
        | masked_any(misc_src, {16'h0000, regs_reg[5'h11]});
    assign out_two_raw = masked_any(fault_status_i, o2_fault_mask)
        | masked_any(warning_status_i, o2_warn_mask)
        | masked_any(der_alarm_status_i, o2_der_mask)
        | masked_any(state_src, o2_state_mask)
        | masked_any(misc_src, {16'h0000, regs_reg[5'h12]});

    always @(posedge mclk_i) begin
        if (rst_i) begin
            status_output_one_o <= 1'b0;
            status_output_two_o <= 1'b0;
        end else begin
            status_output_one_o <= out_one_raw ^ regs_reg[`DITS_IDX_POL][0];
            status_output_two_o <= out_two_raw ^ regs_reg[`DITS_IDX_POL][1];
        end
    end

endmodule

// >>> tb/dits_checker_assertions.sv
// Port assertions for the discrete I/O sequencer
`timescale 1ns/10ps
`include "dits_defines.vh"
module dits_checker #(
    parameter [31:0] TICK_CYCLES = 32'd20,
    parameter [31:0] BIAS_HOLD_CYCLES = 32'd50
) (
    input wire mclk_i,
    input wire rst_i,
    input wire emergency_stop_input_i,
    input wire bias_request_i,
    input wire req_valid_i,
    input wire [7:0] req_unit_i,
    input wire [15:0] req_addr_i,
    input wire req_write_i,
    input wire [15:0] req_wdata_i,
    input wire rsp_valid_o,
    input wire contactor_close_o,
    input wire emergency_stop_input_fault_o,
    input wire bias_enable_o,
    input wire inverter_on_o,
    input wire initial_ramp_o,
    input wire rate_ramp_o,
    input wire [5:0] op_state_o
);
    reg [31:0] low_cnt;
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Cycles since the bias request dropped
    always @(posedge mclk_i) begin
        if (rst_i || bias_request_i) begin
            low_cnt <= 32'h0;
        end else if (low_cnt < BIAS_HOLD_CYCLES + 32'h8) begin
            low_cnt <= low_cnt + 32'h1;
        end
    end
    sequence s_op_wr(u, val);
        req_valid_i && req_write_i && req_addr_i == `DITS_OFF_OPCMD && req_unit_i == u && req_wdata_i == val;
    endsequence
    a_close_needs_emergency_stop_input: assert property (contactor_close_o |-> emergency_stop_input_i)
        else $error("contactor closed without emergency_stop_input");
    a_emergency_stop_input_forces_off: assert property (!emergency_stop_input_i |=> op_state_o == 6'h01)
        else $error("state not off after emergency_stop_input drop");
    a_emergency_stop_input_fault_shown: assert property (!emergency_stop_input_i ##1 !emergency_stop_input_i |-> emergency_stop_input_fault_o)
        else $error("emergency_stop_input fault missing");
    a_bias_follows_req: assert property (bias_request_i |=> bias_enable_o)
        else $error("bias off while requested");
    a_bias_hold_on: assert property (!bias_request_i && low_cnt <= BIAS_HOLD_CYCLES - 32'h2 |-> bias_enable_o)
        else $error("bias dropped early");
    a_bias_then_off: assert property (low_cnt >= BIAS_HOLD_CYCLES + 32'h4 |-> !bias_enable_o)
        else $error("bias held too long");
    a_closed_after_start: assert property (contactor_close_o |-> (op_state_o & 6'h3c) != 6'h00)
        else $error("contactor closed before standby");
    a_bcast_start_acts: assert property (
        s_op_wr(8'h00, `DITS_CMD_START) ##0 (op_state_o == 6'h01 && emergency_stop_input_i) |=> op_state_o == 6'h02)
        else $error("broadcast start ignored");
    a_bcast_exit_acts: assert property (
        s_op_wr(8'h00, `DITS_CMD_EXIT_STBY) ##0 (op_state_o == 6'h04 && emergency_stop_input_i)
        |=> op_state_o[3] || op_state_o[4])
        else $error("broadcast exit ignored");
    a_bcast_no_reply: assert property (req_valid_i && req_unit_i == 8'h00 |=> !rsp_valid_o)
        else $error("reply to broadcast");
    a_reply_has_cause: assert property (rsp_valid_o |-> $past(req_valid_i) && $past(req_unit_i) != 8'h00)
        else $error("reply without request");
    a_ramp_stages: assert property ((initial_ramp_o || rate_ramp_o) |-> inverter_on_o && !(initial_ramp_o && rate_ramp_o))
        else $error("ramp outputs inconsistent");
endmodule
bind dits_sequencer dits_checker #(.TICK_CYCLES(TICK_CYCLES), .BIAS_HOLD_CYCLES(BIAS_HOLD_CYCLES)) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .emergency_stop_input_i(emergency_stop_input_i),
    .bias_request_i(bias_request_i), .req_valid_i(req_valid_i), .req_unit_i(req_unit_i),
    .req_addr_i(req_addr_i), .req_write_i(req_write_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .contactor_close_o(contactor_close_o), .emergency_stop_input_fault_o(emergency_stop_input_fault_o),
    .bias_enable_o(bias_enable_o), .inverter_on_o(inverter_on_o), .initial_ramp_o(initial_ramp_o),
    .rate_ramp_o(rate_ramp_o), .op_state_o(op_state_o)
);

// >>> tb/dits_host_model.sv
// Bus master and power stage model facing the sequencer
`timescale 1ns/10ps
module dits_host_model (
    input wire clk_i,
    input wire charge_i,
    input wire rsp_v_i,
    input wire [15:0] rsp_d_i,
    input wire rsp_e_i,
    output reg valid_o,
    output reg [7:0] unit_o,
    output reg [15:0] addr_o,
    output reg write_o,
    output reg [15:0] wdata_o,
    output reg done_o
);
    integer pre_dly = 0;
    integer pre_cnt = 0;
    initial begin
        valid_o = 1'b0;
        unit_o = 8'hff;
        addr_o = 16'hffff;
        write_o = 1'b0;
        wdata_o = 16'hffff;
    end
    // Pre-charge ends pre_dly cycles after it starts
    always @(posedge clk_i) begin
        if (charge_i) begin
            pre_cnt <= pre_cnt + 1;
        end else begin
            pre_cnt <= 0;
        end
    end
    always @* done_o = charge_i && (pre_cnt >= pre_dly);
    // One request pulse, reply sampled a cycle later
    task xfer(input [7:0] u, input [15:0] a, input w, input [15:0] d, output v, output [15:0] q, output e);
        begin
            @(negedge clk_i);
            valid_o = 1'b1;
            unit_o = u;
            addr_o = a;
            write_o = w;
            wdata_o = d;
            @(negedge clk_i);
            v = rsp_v_i;
            q = rsp_d_i;
            e = rsp_e_i;
            valid_o = 1'b0;
            unit_o = ~u;
            addr_o = ~a;
            wdata_o = ~d;
        end
    endtask
endmodule

// >>> tb/dits_sequencer_tb_top.sv
// Self-checking bench for the discrete I/O sequencer
`timescale 1ns/10ps
`include "dits_defines.vh"
module dits_sequencer_tb_top;
    reg mclk_i = 1'b0;
    reg rst_i = 1'b1;
    reg emergency_stop_input = 1'b0;
    reg bias = 1'b1;
    reg island = 1'b0; // Left open means grid tie
    reg grid = 1'b0;
    reg [31:0] flt = 32'h0;
    reg [31:0] wrn = 32'h0;
    reg [31:0] der = 32'h0;
    reg [15:0] msc = 16'h0;
    reg [159:0] lo_tbl = {`DITS_OFF_O2M, `DITS_OFF_O2S_LO, `DITS_OFF_O2D_LO, `DITS_OFF_O2W_LO, `DITS_OFF_O2F_LO,
        `DITS_OFF_O1M, `DITS_OFF_O1S_LO, `DITS_OFF_O1D_LO, `DITS_OFF_O1W_LO, `DITS_OFF_O1F_LO};
    wire rv, rw, done, sv, se, cc, ef, be, gf, pc, io, ir, rr, o1, o2;
    wire [7:0] ru;
    wire [15:0] ra, rd, sd;
    wire [5:0] st;
    integer n_errors = 0;
    integer n_checks = 0;
    integer i;
    integer k;
    reg v;
    reg e;
    reg [15:0] q;
    always #20 mclk_i = ~mclk_i;
    dits_sequencer #(.TICK_CYCLES(32'd20), .BIAS_HOLD_CYCLES(32'd50)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .emergency_stop_input_i(emergency_stop_input), .bias_request_i(bias), .island_select_i(island), .grid_valid_i(grid),
        .precharge_done_i(done), .fault_status_i(flt), .warning_status_i(wrn), .der_alarm_status_i(der),
        .misc_status_i(msc), .req_valid_i(rv), .req_unit_i(ru), .req_addr_i(ra), .req_write_i(rw),
        .req_wdata_i(rd), .rsp_valid_o(sv), .rsp_data_o(sd), .rsp_error_o(se), .contactor_close_o(cc),
        .emergency_stop_input_fault_o(ef), .bias_enable_o(be), .grid_forming_o(gf), .precharge_o(pc), .inverter_on_o(io),
        .initial_ramp_o(ir), .rate_ramp_o(rr), .op_state_o(st), .status_output_one_o(o1), .status_output_two_o(o2));
    dits_host_model host (.clk_i(mclk_i), .charge_i(pc), .rsp_v_i(sv), .rsp_d_i(sd), .rsp_e_i(se),
        .valid_o(rv), .unit_o(ru), .addr_o(ra), .write_o(rw), .wdata_o(rd), .done_o(done));
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== ex) begin
                n_errors = n_errors + 1;
                $display("wrong value %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    // Access with reply, error flag and data expected when rep is set
    task acc(input [7:0] u, input [15:0] a, input w, input [15:0] d, input rep, input er, input [15:0] ex);
        begin
            host.xfer(u, a, w, d, v, q, e);
            chk("reply", {31'h0, rep}, {31'h0, v});
            if (rep) begin
                chk("error", {31'h0, er}, {31'h0, e});
                chk("data", {16'h0, ex}, {16'h0, q});
            end
        end
    endtask
    task wait_st(input [5:0] s);
        begin
            k = 0;
            while (st !== s && k < 400) begin
                @(negedge mclk_i);
                k = k + 1;
            end
            chk("state", {26'h0, s}, {26'h0, st});
            if (k >= 400) begin
                print_verdict;
            end
        end
    endtask
    initial begin
        repeat (6) @(negedge mclk_i);
        rst_i = 1'b0;
        acc(8'h01, `DITS_OFF_UNIT, 1'b0, 16'h0, 1'b1, 1'b0, `DITS_RST_UNIT);
        acc(8'h01, `DITS_OFF_POL, 1'b0, 16'h0, 1'b1, 1'b0, 16'h0000);
        acc(8'h01, 16'ha3aa, 1'b1, 16'h1234, 1'b1, 1'b1, 16'h0000);
        for (i = 0; i < 10; i = i + 1) begin
            flt = (i % 5 == 0) ? 32'h1 : 32'h0;
            wrn = (i % 5 == 1) ? 32'h1 : 32'h0;
            der = (i % 5 == 2) ? 32'h1 : 32'h0;
            msc = (i % 5 == 4) ? 16'h1 : 16'h0;
            acc(8'h01, lo_tbl[16*i +: 16], 1'b0, 16'h0, 1'b1, 1'b0, 16'h0000);
            acc(8'h01, lo_tbl[16*i +: 16], 1'b1, 16'h0001, 1'b1, 1'b0, 16'h0001);
            repeat (2) @(negedge mclk_i);
            chk("out one", {31'h0, i < 5}, {31'h0, o1});
            chk("out two", {31'h0, i >= 5}, {31'h0, o2});
            acc(8'h01, lo_tbl[16*i +: 16], 1'b1, 16'h0000, 1'b1, 1'b0, 16'h0000);
            repeat (2) @(negedge mclk_i);
            chk("masked", 32'h0, {31'h0, o1 | o2});
        end
        msc = 16'h0;
        for (i = 0; i < 4; i = i + 1) begin
            acc(8'h01, `DITS_OFF_O1F_HI + i[15:0], 1'b1, 16'hffff, 1'b1, 1'b0, 16'hffff);
        end
        flt = 32'h8000_0000;
        repeat (2) @(negedge mclk_i);
        chk("fault on", 32'h1, {31'h0, o1});
        flt = 32'h0;
        wrn = 32'h0002_0000;
        repeat (2) @(negedge mclk_i);
        chk("warn on", 32'h1, {31'h0, o1});
        wrn = 32'h0;
        acc(8'h01, `DITS_OFF_POL, 1'b1, 16'h0002, 1'b1, 1'b0, 16'h0002);
        repeat (2) @(negedge mclk_i);
        chk("pol", 32'h1, {30'h0, o1, o2});
        chk("closed", 32'h0, {31'h0, cc});
        acc(8'h01, `DITS_OFF_OPCMD, 1'b1, `DITS_CMD_START, 1'b1, 1'b0, 16'h0001);
        repeat (2) @(negedge mclk_i);
        chk("off", 32'h1, {26'h0, st});
        chk("emergency_stop_input fault", 32'h1, {31'h0, ef});
        emergency_stop_input = 1'b1;
        acc(8'h01, `DITS_OFF_OPCMD, 1'b1, `DITS_CMD_START, 1'b1, 1'b0, 16'h0001);
        repeat (4) @(negedge mclk_i);
        chk("charge", 32'h2, {26'h0, st});
        chk("open", 32'h0, {29'h0, cc, ef, pc});
        host.pre_dly = 6;
        grid = 1'b1;
        @(negedge mclk_i);
        chk("precharge", 32'h1, {31'h0, pc});
        wait_st(6'h04);
        @(negedge mclk_i);
        chk("closed", 32'h1, {31'h0, cc});
        acc(8'h01, `DITS_OFF_OPCMD, 1'b1, `DITS_CMD_EXIT_STBY, 1'b1, 1'b0, 16'h0003);
        chk("ramp", 32'h13, {26'h0, st[5:2], ir, io});
        @(negedge mclk_i);
        chk("run", 32'h21, {26'h0, st[5:1], rr});
        emergency_stop_input = 1'b0;
        @(negedge mclk_i);
        chk("stop", 32'h2, {25'h0, st, cc});
        emergency_stop_input = 1'b1;
        acc(8'h05, `DITS_OFF_WINDOW, 1'b1, 16'h0009, 1'b0, 1'b0, 16'h0);
        acc(8'h01, `DITS_OFF_WINDOW, 1'b0, 16'h0, 1'b1, 1'b0, 16'h0000);
        acc(8'h00, `DITS_OFF_WINDOW, 1'b1, 16'h0002, 1'b0, 1'b0, 16'h0);
        acc(8'h00, `DITS_OFF_RAMP, 1'b1, 16'h0001, 1'b0, 1'b0, 16'h0);
        acc(8'h00, `DITS_OFF_OPCMD, 1'b1, `DITS_CMD_START, 1'b0, 1'b0, 16'h0);
        wait_st(6'h04);
        acc(8'h00, `DITS_OFF_OPCMD, 1'b1, `DITS_CMD_EXIT_STBY, 1'b0, 1'b0, 16'h0);
        chk("delay", 32'h08, {26'h0, st});
        wait_st(6'h10);
        chk("init ramp", 32'h3, {30'h0, ir, io});
        wait_st(6'h20);
        chk("rate ramp", 32'h1, {31'h0, rr});
        acc(8'h01, `DITS_OFF_OPCMD, 1'b1, `DITS_CMD_STOP, 1'b1, 1'b0, `DITS_CMD_STOP);
        chk("stopped", 32'h2, {25'h0, st, cc});
        acc(8'h01, `DITS_OFF_WINDOW, 1'b0, 16'h0, 1'b1, 1'b0, 16'h0002);
        island = 1'b1;
        bias = 1'b0;
        repeat (48) @(negedge mclk_i);
        chk("bias held", 32'h3, {30'h0, be, gf});
        repeat (6) @(negedge mclk_i);
        chk("bias off", 32'h0, {31'h0, be});
        bias = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk("bias on", 32'h1, {31'h0, be});
        print_verdict;
    end
endmodule
